// ===== src/tli_pkg.sv
package tli_pkg;

  // Operand size selects
  typedef enum logic [1:0] {
    TLI_SZ_BYTE,
    TLI_SZ_WORD,
    TLI_SZ_LONG
  } tli_size_e;

  localparam int TLI_FRAC_W    = 8;
  localparam int TLI_OFS_LSB   = 8;
  localparam int TLI_OFS_MSB   = 15;
  localparam int TLI_FRAC_MSB  = 7;
  localparam int TLI_FRAC_LSB  = 0;
  localparam int TLI_DATA_W    = 32;
  localparam int TLI_ACC_W     = 42;
  localparam int TLI_BYTE_W    = 8;
  localparam int TLI_WORD_W    = 16;

  // One lookup request from the sequencer
  typedef struct packed {
    logic            is_signed;   // signed vs unsigned table values
    logic            do_round;    // rounded vs unrounded variant
    logic            reg_pair;    // data from register pair, not memory
    tli_size_e       size;
    logic [31:0]     index_reg;   // index_register contents
    logic [31:0]     pair_lo;     // first endpoint when reg_pair set
    logic [31:0]     pair_hi;     // second endpoint when reg_pair set
  } tli_req_s;

  // Operand fetch request to the memory path
  typedef struct packed {
    logic [7:0]      entry;       // entry number to read
  } tli_fetch_s;

endpackage

// ===== src/tli_interp_core.sv
`timescale 1ns/1ps
module tli_interp_core
  import tli_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // Operands
  input  wire logic                  start,
  input  wire logic                  is_signed,
  input  wire logic                  do_round,
  input  wire tli_size_e             size,
  input  wire logic [TLI_DATA_W-1:0] entry_a,
  input  wire logic [TLI_DATA_W-1:0] entry_b,
  input  wire logic [TLI_FRAC_W-1:0] frac,
  // Result
  output logic                       done,
  output logic [TLI_DATA_W-1:0]      result_r
);

  logic signed [TLI_ACC_W-1:0] a_ext;
  logic signed [TLI_ACC_W-1:0] b_ext;
  logic signed [TLI_ACC_W-1:0] scaled;
  logic signed [TLI_ACC_W-1:0] rounded;
  logic        [TLI_DATA_W-1:0] result_nxt;
  logic                         done_r;

  // Sign or zero extend each entry from the operand size
  function automatic logic signed [TLI_ACC_W-1:0] ext(input logic [TLI_DATA_W-1:0] v, input logic sgn,
                                                      input tli_size_e sz);
    logic signed [TLI_ACC_W-1:0] r;
    r = '0;
    case (sz)
      TLI_SZ_BYTE: r = sgn ? TLI_ACC_W'(signed'(v[TLI_BYTE_W-1:0])) : TLI_ACC_W'(v[TLI_BYTE_W-1:0]);
      TLI_SZ_WORD: r = sgn ? TLI_ACC_W'(signed'(v[TLI_WORD_W-1:0])) : TLI_ACC_W'(v[TLI_WORD_W-1:0]);
      default:     r = sgn ? TLI_ACC_W'(signed'(v)) : TLI_ACC_W'(v);
    endcase
    return r;
  endfunction

  always_comb
  begin
    a_ext  = ext(entry_a, is_signed, size);
    b_ext  = ext(entry_b, is_signed, size);
    // Kept scaled by 256 so the unrounded variants lose no fraction bits
    scaled = TLI_ACC_W'(a_ext <<< TLI_FRAC_W)
           + TLI_ACC_W'(signed'({1'b0, frac}) * (b_ext - a_ext));
    // Round half to even: bump on fraction above half, or exactly half with odd integer
    rounded = scaled >>> TLI_FRAC_W;
    if (scaled[TLI_FRAC_W-1] && ((scaled[TLI_FRAC_W-2:0] != '0) || scaled[TLI_FRAC_W]))
    begin
      rounded = rounded + TLI_ACC_W'(1);
    end
    if (do_round)
    begin
      result_nxt = rounded[TLI_DATA_W-1:0];
    end
    else
    begin
      result_nxt = scaled[TLI_DATA_W-1:0];
    end
    // Rounded results are trimmed to the operand size
    if (do_round && size == TLI_SZ_BYTE)
    begin
      result_nxt = {{(TLI_DATA_W-TLI_BYTE_W){1'b0}}, rounded[TLI_BYTE_W-1:0]};
    end
    else if (do_round && size == TLI_SZ_WORD)
    begin
      result_nxt = {{(TLI_DATA_W-TLI_WORD_W){1'b0}}, rounded[TLI_WORD_W-1:0]};
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      result_r <= '0;
    end
    else if (start)
    begin
      result_r <= result_nxt;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      done_r <= 1'b0;
    end
    else
    begin
      done_r <= start;
    end
  end

  assign done = done_r;

endmodule // tli_interp_core

// ===== src/tli_table_lookup_interpolator.sv
`timescale 1ns/1ps
module tli_table_lookup_interpolator
  import tli_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // Sequencer request
  input  wire logic                  req_valid,
  input  wire tli_req_s              req,
  output logic                       req_ready,
  // Operand memory path
  output logic                       fetch_valid,
  output tli_fetch_s                 fetch_r,
  input  wire logic                  fetch_ack,
  input  wire logic [TLI_DATA_W-1:0] fetch_data,
  // Result
  output logic                       res_valid,
  output logic [TLI_DATA_W-1:0]      res_data
);

  typedef enum logic [2:0] {
    TLI_IDLE,
    TLI_FETCH_A,
    TLI_FETCH_B,
    TLI_CALC,
    TLI_WAIT
  } tli_state_e;

  tli_state_e                state_r;
  tli_req_s                  req_r;
  logic [TLI_DATA_W-1:0]     ent_a_r;
  logic [TLI_DATA_W-1:0]     ent_b_r;
  logic [TLI_FRAC_W-1:0]     frac_w;
  logic                      core_start;
  logic                      core_done;

  assign req_ready   = (state_r == TLI_IDLE);
  assign fetch_valid = (state_r == TLI_FETCH_A) || (state_r == TLI_FETCH_B);
  assign core_start  = (state_r == TLI_CALC);
  assign frac_w      = req_r.index_reg[TLI_FRAC_MSB:TLI_FRAC_LSB];
  assign res_valid   = core_done;

  // Sequencing; a register pair skips both memory fetches
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_r <= TLI_IDLE;
    end
    else
    begin
      case (state_r)
        TLI_IDLE:
        begin
          if (req_valid)
          begin
            state_r <= req.reg_pair ? TLI_CALC : TLI_FETCH_A;
          end
        end
        TLI_FETCH_A:
        begin
          if (fetch_ack)
          begin
            state_r <= TLI_FETCH_B;
          end
        end
        TLI_FETCH_B:
        begin
          if (fetch_ack)
          begin
            state_r <= TLI_CALC;
          end
        end
        TLI_CALC: state_r <= TLI_WAIT;
        TLI_WAIT: state_r <= TLI_IDLE;
        default:  state_r <= TLI_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      req_r <= '0;
    end
    else if (req_ready && req_valid)
    begin
      req_r <= req;
    end
  end

  // Entry address: selected entry, then the next one
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      fetch_r <= '0;
    end
    else if (req_ready && req_valid)
    begin
      fetch_r.entry <= req.index_reg[TLI_OFS_MSB:TLI_OFS_LSB];
    end
    else if (state_r == TLI_FETCH_A && fetch_ack)
    begin
      // Wraps at 255; software keeps the table one entry past the last offset
      fetch_r.entry <= fetch_r.entry + 8'h01;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ent_a_r <= '0;
      ent_b_r <= '0;
    end
    else if (req_ready && req_valid && req.reg_pair)
    begin
      ent_a_r <= req.pair_lo;
      ent_b_r <= req.pair_hi;
    end
    else if (state_r == TLI_FETCH_A && fetch_ack)
    begin
      ent_a_r <= fetch_data;
    end
    else if (state_r == TLI_FETCH_B && fetch_ack)
    begin
      ent_b_r <= fetch_data;
    end
  end

  tli_interp_core u_core (
    .clk       (clk),
    .rst_n     (rst_n),
    .start     (core_start),
    .is_signed (req_r.is_signed),
    .do_round  (req_r.do_round),
    .size      (req_r.size),
    .entry_a   (ent_a_r),
    .entry_b   (ent_b_r),
    .frac      (frac_w),
    .done      (core_done),
    .result_r  (res_data)
  );

endmodule // tli_table_lookup_interpolator

// ===== test/tli_chk.sv
`timescale 1ns/1ps
module tli_chk
  import tli_pkg::*;
(
  // Top ports
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        req_valid,
  input wire tli_req_s    req,
  input wire logic        req_ready,
  input wire logic        fetch_valid,
  input wire tli_fetch_s  fetch_r,
  input wire logic        fetch_ack,
  input wire logic [31:0] fetch_data,
  input wire logic        res_valid,
  input wire logic [31:0] res_data
);
  logic [7:0] ent_r;
  wire        take = req_valid && req_ready;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge clk)
    if (!rst_n) ent_r <= 8'h00;
    else if (take) ent_r <= req.index_reg[15:8];
  sequence s_pair; take && req.reg_pair; endsequence
  sequence s_ack1; fetch_valid && fetch_ack && fetch_r.entry == ent_r; endsequence
  sequence s_ack2; fetch_valid && fetch_ack && fetch_r.entry == ent_r + 8'h01; endsequence
  a_pair_time: assert property (s_pair |-> ##2 res_valid) else $error("late pair result");
  a_pair_nofetch: assert property (s_pair |=> !fetch_valid [*2]) else $error("pair fetched");
  a_first_entry: assert property (take && !req.reg_pair |=> fetch_valid && fetch_r.entry == ent_r)
    else $error("first entry");
  a_next_entry: assert property (s_ack1 |=> fetch_valid && fetch_r.entry == ent_r + 8'h01)
    else $error("next entry");
  a_mem_time: assert property (s_ack2 |-> ##2 res_valid) else $error("late mem result");
  a_fetch_hold: assert property (fetch_valid && !fetch_ack |=> fetch_valid && $stable(fetch_r))
    else $error("fetch dropped");
  a_res_pulse: assert property (res_valid |=> !res_valid && req_ready) else $error("res pulse");
  a_res_hold: assert property (!res_valid |-> $stable(res_data)) else $error("res moved");
  a_busy_ready: assert property (take |=> !req_ready ##1 !req_ready) else $error("ready early");
endmodule // tli_chk

bind tli_table_lookup_interpolator tli_chk chk_i (.*);

// ===== test/tli_mem_model.sv
`timescale 1ns/1ps
module tli_mem_model
  import tli_pkg::*;
(
  // Memory path
  input wire logic        clk,
  input wire logic        fetch_valid,
  input wire tli_fetch_s  fetch_r,
  input wire logic [3:0]  lat,
  output logic            fetch_ack,
  output logic [31:0]     fetch_data
);
  logic [31:0] mem [256];
  logic [31:0] last_r = 32'h0;
  logic [3:0]  wait_r = 4'h0;
  initial
  begin
    fetch_ack = 1'b0;
    fetch_data = 32'h0;
  end
  // Idle data is the inverse of the last word, so a late sample never looks right
  always @(posedge clk)
    if (fetch_valid && !fetch_ack && wait_r == lat)
    begin
      fetch_ack <= #1 1'b1;
      fetch_data <= #1 mem[fetch_r.entry];
      last_r <= mem[fetch_r.entry];
      wait_r <= 4'h0;
    end
    else
    begin
      fetch_ack <= #1 1'b0;
      fetch_data <= #1 ~last_r;
      wait_r <= (fetch_valid && !fetch_ack) ? wait_r + 4'h1 : 4'h0;
    end
endmodule // tli_mem_model

// ===== test/tli_table_lookup_interpolator_test.sv
`timescale 1ns/1ps
module tli_table_lookup_interpolator_test
  import tli_pkg::*;
;
  logic        clk, rst_n, req_valid, req_ready, fetch_valid, fetch_ack, res_valid;
  logic [3:0]  lat;
  logic [31:0] fetch_data, res_data, d;
  tli_req_s    req, r;
  tli_fetch_s  fetch_r;
  int          err_count, samples_checked;
  tli_table_lookup_interpolator dut (.*);
  tli_mem_model mem_i (.*);
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic print_verdict;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] exp_f(input logic s, rn, input int z, input logic [31:0] a, b,
                                        input logic [7:0] f);
    longint m, x, y, v, q;
    m = (64'h1 << (8 << z)) - 1;
    x = a & m;
    y = b & m;
    if (s && x > m / 2) x -= m + 1;
    if (s && y > m / 2) y -= m + 1;
    v = x * 256 + longint'(f) * (y - x);
    if (!rn) return v[31:0];
    q = v >>> 8;
    if (v[7:0] > 8'h80 || (v[7:0] == 8'h80 && q[0])) q++;
    return q[31:0] & m[31:0];
  endfunction
  // Entered just after an edge; a request raised while busy must wait, never queue
  task automatic run;
    int n;
    req = r;
    req_valid = 1'b1;
    for (n = 0; n < 40 && req_ready !== 1'b1; n++) @(posedge clk) #1;
    if (req_ready !== 1'b1)
    begin
      err_count++;
      $display("Error %0t never ready", $time);
      print_verdict;
    end
    @(posedge clk) #1;
    req_valid = 1'b0;
    for (n = 0; n < 40 && res_valid !== 1'b1; n++) @(posedge clk) #1;
    d = res_data;
    if (res_valid !== 1'b1)
    begin
      err_count++;
      $display("Error %0t no result", $time);
      print_verdict;
    end
  endtask
  task automatic t_pair;
    r = '0;
    r.reg_pair = 1'b1;
    r.pair_lo = 32'hffff_fff5;
    r.pair_hi = 32'h0000_000a;
    for (int k = 0; k < 24; k++)
    begin
      r.is_signed = k[2];
      r.do_round = k[1];
      r.size = tli_size_e'(k / 8);
      r.index_reg = {24'hffa301, k[0] ? 8'h41 : 8'h80};
      run;
      chk(d, exp_f(k[2], k[1], k / 8, r.pair_lo, r.pair_hi, r.index_reg[7:0]));
    end
    // A tie on an even integer must not be bumped
    r.is_signed = 1'b1;
    r.do_round = 1'b1;
    r.size = TLI_SZ_WORD;
    r.pair_lo = 32'h0000_0002;
    r.pair_hi = 32'h0000_0003;
    r.index_reg = 32'h0000_0080;
    run;
    chk(d, 32'h0000_0002);
    r.do_round = 1'b0;
    run;
    chk(d, 32'h0000_0280);
    $display("pair done");
  endtask
  task automatic t_mem;
    r = '0;
    r.do_round = 1'b1;
    r.size = TLI_SZ_WORD;
    r.index_reg = 32'h0000_a380;
    mem_i.mem[163] = 32'h0000_0685;
    mem_i.mem[164] = 32'h0000_068f;
    lat = 4'h3;
    run;
    chk(d, 32'h0000_068a);
    mem_i.mem[255] = 32'h8000_0010;
    mem_i.mem[0] = 32'h7fff_fff0;
    r.size = TLI_SZ_LONG;
    r.index_reg = 32'h1234_ff40;
    for (int k = 0; k < 4; k++)
    begin
      r.is_signed = k[1];
      r.do_round = k[0];
      lat = 4'(k);
      run;
      chk(d, exp_f(k[1], k[0], 2, 32'h8000_0010, 32'h7fff_fff0, 8'h40));
    end
    $display("mem done");
  endtask
  initial
  begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    req = '0;
    lat = 4'h0;
    err_count = 0;
    samples_checked = 0;
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
    t_pair;
    t_mem;
    print_verdict;
  end
endmodule // tli_table_lookup_interpolator_test
